// ===== scr_cfg.svh
// Constants of the supply, reset and clock controller
//
// Behaviour
// RULE1 - Backup supply POR always resets everything; the supply monitor alarm is not cleared by it
// RULE2 - Core brownout on after reset, disableable
// RULE3 - Supply monitor off, sixteen threshold steps
// RULE4 - Sampled monitor mode, ratio up to 2048
// RULE5 - Record last reset cause, five kinds
// RULE6 - Drive shaped pulse on external reset pin
// RULE7 - Supply control on slow tick, own POR
// RULE8 - Slow clock RC first, crystal by software
// RULE9 - Unselected slow oscillator switched off
// RULE10 - Regulator enabled before core reset release
// RULE11 - Fast RC 4, 8, 12 MHz; 4 default
// RULE12 - Master clock from fast RC after startup
// RULE13 - USB PLL 480 MHz, 12 MHz reference
// RULE14 - Bypass mode for both crystal oscillators
// RULE15 - Processor, free, master, USB, peripheral, programmable clocks
// RULE16 - Tick calibration fixed at 10500
`ifndef SCR_CFG_SVH
`define SCR_CFG_SVH

// Clock rates
`define SCR_MCLK_HZ      200000000
`define SCR_MCLK_KHZ     200000
`define SCR_SLOW_HZ      32768
`define SCR_SLOW_DIV     (`SCR_MCLK_HZ / `SCR_SLOW_HZ)
`define SCR_FRC4_KHZ     4000
`define SCR_FRC8_KHZ     8000
`define SCR_FRC12_KHZ    12000
`define SCR_MAIN_KHZ     12000
`define SCR_PLL_KHZ      84000

// Sequencing times, in slow clock periods
`define SCR_REG_TICKS    8'h04
`define SCR_CORE_TICKS   8'h03
`define SCR_ERST_TICKS   8'h08
`define SCR_XTAL_TICKS   8'h10

// Supply monitor sampling periods, in slow clock periods
`define SCR_SMP_P256     12'h100
`define SCR_SMP_P2048    12'h800

// Fixed values
`define SCR_SYSTICK_CAL  24'h002904
`define SCR_USB_HS_PLL_MULT    6'h28

// Reset values of the configuration
`define SCR_RST_BOD_DIS  1'b0
`define SCR_RST_SMON_EN  1'b0
`define SCR_RST_SMON_THR 4'h0

`endif

// ===== scr_pkg.sv
// Types of the supply, reset and clock controller
package scr_pkg;

   typedef enum logic [1:0] {SCR_FRC_4M, SCR_FRC_8M, SCR_FRC_12M} scr_frc_t;
   typedef enum logic [1:0] {SCR_MCK_FRC, SCR_MCK_MAIN, SCR_MCK_PLL} scr_mck_t;
   typedef enum logic [1:0] {SCR_SMP_CONT, SCR_SMP_256, SCR_SMP_2048} scr_smp_t;
   typedef enum logic [2:0] {
      SCR_RC_GENERAL, SCR_RC_WAKEUP, SCR_RC_SOFTWARE, SCR_RC_USER, SCR_RC_WATCHDOG
   } scr_cause_t;

   // Software configuration, loaded as one word
   typedef struct packed {
      logic     bod_dis;
      logic     smon_en;
      logic [3:0] smon_thr;
      scr_smp_t smon_smp;
      logic     xtal32_en;
      logic     xtal32_sel;
      logic     xtal32_byp;
      logic     main_byp;
      scr_frc_t frc_sel;
      scr_mck_t mck_src;
   } scr_cfg_t;

   // Reset requests from elsewhere in the chip
   typedef struct packed {
      logic sw;
      logic wdt;
      logic wake;
   } scr_req_t;

endpackage

// ===== scr_div.sv
// Enable-pulse divider
`timescale 1ns/1ps
module scr_div #(
   parameter int W = 16
) (
   input  wire logic         mclk_i,
   input  wire logic         rst_i,
   input  wire logic         en_i,
   input  wire logic [W-1:0] lim_i,
   output logic              tick_o
);

   logic [W-1:0] cnt_q;

   // Counts enabled cycles; one pulse every lim_i+1 of them
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_q  <= '0;
         tick_o <= 1'b0;
      end else if (en_i) begin
         if (cnt_q >= lim_i) begin
            cnt_q  <= '0;
            tick_o <= 1'b1;
         end else begin
            cnt_q  <= cnt_q + 1'b1;
            tick_o <= 1'b0;
         end
      end else begin
         tick_o <= 1'b0;
      end
   end

endmodule // scr_div

// ===== scr_ctrl.sv
// Supply supervision, reset control and clock generation
`timescale 1ns/1ps
`include "scr_cfg.svh"
module scr_ctrl #(
   parameter int SLOW_DIV = `SCR_SLOW_DIV,
   parameter int NPER     = 8
) (
   input  wire logic                mclk_i,
   input  wire logic                rst_i,
   input  wire logic                backup_supply_low_i,
   input  wire logic                core_supply_low_i,
   input  wire logic                usb_phy_supply_low_i,
   input  wire scr_pkg::scr_cfg_t   cfg_i,
   input  wire logic                cfg_wr_i,
   input  wire scr_pkg::scr_req_t   req_i,
   input  wire logic                smon_clr_i,
   input  wire logic                external_reset_pin_i,
   input  wire logic                usb_pll_req_i,
   input  wire logic                main_ref_12m_i,
   input  wire logic                usb_hs_pll_lock_i,
   input  wire logic                cpu_sleep_i,
   input  wire logic [NPER-1:0]     periph_gate_i,
   input  wire logic [2:0]          pck_on_i,
   input  wire logic [8:0]          pck_pres_i,
   output logic                     regulator_en_o,
   output logic                     core_reset_o,
   output logic                     sys_reset_o,
   output logic                     external_reset_pin_o,
   output logic                     external_reset_pin_oe_o,
   output scr_pkg::scr_cause_t      reset_cause_o,
   output logic                     smon_power_o,
   output logic [3:0]               smon_thr_o,
   output logic                     smon_alarm_o,
   output logic                     rc_slow_en_o,
   output logic                     xtal32_en_o,
   output logic                     slow_is_xtal_o,
   output logic                     xtal32_byp_o,
   output logic                     main_osc_en_o,
   output logic                     main_byp_o,
   output scr_pkg::scr_frc_t        frc_sel_o,
   output scr_pkg::scr_mck_t        mck_src_o,
   output logic                     usb_hs_pll_en_o,
   output logic [5:0]               usb_hs_pll_mult_o,
   output logic                     cpu_clk_en_o,
   output logic                     free_running_cpu_clock_en_o,
   output logic                     master_clock_en_o,
   output logic                     usb_hs_clock_en_o,
   output logic [NPER-1:0]          periph_clk_en_o,
   output logic [2:0]               pck_en_o,
   output logic [23:0]              systick_calib_o
);

   typedef enum logic [1:0] {SUP_OFF, SUP_REG, SUP_CORE, SUP_RUN} scr_sup_t;

   ////////////////////////////////////////////////////////////////////////////
   // Parameter checks

   if (SLOW_DIV < 2 || SLOW_DIV > 65536) begin : g_chk_div
      $error("SLOW_DIV out of range");
   end
   if (NPER < 1) begin : g_chk_per
      $error("NPER must be at least one");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   // Master clock divider limit for a source and fast RC setting
   function automatic logic [7:0] mck_lim(scr_pkg::scr_mck_t src, scr_pkg::scr_frc_t frc);
      int khz;
      khz = `SCR_FRC4_KHZ;
      case (src)
         scr_pkg::SCR_MCK_MAIN: khz = `SCR_MAIN_KHZ;
         scr_pkg::SCR_MCK_PLL:  khz = `SCR_PLL_KHZ;
         default: begin
            case (frc)
               scr_pkg::SCR_FRC_8M:  khz = `SCR_FRC8_KHZ;
               scr_pkg::SCR_FRC_12M: khz = `SCR_FRC12_KHZ;
               default:              khz = `SCR_FRC4_KHZ;
            endcase
         end
      endcase
      return 8'(`SCR_MCLK_KHZ / khz - 1);
   endfunction

   // Supply monitor sample period in slow clock periods
   function automatic logic [11:0] smp_period(scr_pkg::scr_smp_t m);
      case (m)
         scr_pkg::SCR_SMP_256:  return `SCR_SMP_P256;
         scr_pkg::SCR_SMP_2048: return `SCR_SMP_P2048;
         default:               return 12'h001;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Declarations

   scr_pkg::scr_cfg_t   cfg_q;
   scr_pkg::scr_cause_t cause_q;
   scr_sup_t            sup_q;
   logic [7:0]          sup_cnt_q;
   logic [7:0]          erst_cnt_q;
   logic [7:0]          xtal_cnt_q;
   logic [11:0]         smp_cnt_q;
   logic [7:0]          mck_lim_q;
   logic                bod_trip_q;
   logic                slow_sel_q;
   logic                alarm_q;
   logic                usb_hs_pll_en_q;
   logic                slow_tick;
   logic                mck_tick;
   logic                user_low;
   logic                rst_start;
   logic                xtal_req;

   ////////////////////////////////////////////////////////////////////////////
   // Configuration

   // Loaded on a write strobe and cleared by backup supply low; reset puts the documented defaults
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         cfg_q          <= '0;
         cfg_q.bod_dis  <= `SCR_RST_BOD_DIS; // RULE2
         cfg_q.smon_en  <= `SCR_RST_SMON_EN; // RULE3
         cfg_q.smon_thr <= `SCR_RST_SMON_THR;
         cfg_q.smon_smp <= scr_pkg::SCR_SMP_CONT;
         cfg_q.frc_sel  <= scr_pkg::SCR_FRC_4M; // RULE11
         cfg_q.mck_src  <= scr_pkg::SCR_MCK_FRC; // RULE12
      end else if (backup_supply_low_i) begin
         cfg_q          <= '0; // RULE1
      end else if (cfg_wr_i) begin
         cfg_q          <= cfg_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Slow clock tick

   // Supply control steps on this tick, backup POR and wake-up aside, as if clocked at 32 kHz
   scr_div #(
      .W (16)
   ) u_slow (
      .mclk_i (mclk_i),
      .rst_i  (rst_i),
      .en_i   (1'b1),
      .lim_i  (16'(SLOW_DIV - 1)), // RULE7
      .tick_o (slow_tick)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Supply sequencer

   // Regulator first, then core reset held a while, then released
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         sup_q     <= SUP_OFF;
         sup_cnt_q <= 8'h00;
      end else if (backup_supply_low_i) begin
         sup_q     <= SUP_OFF; // RULE1
         sup_cnt_q <= 8'h00;
      end else if (req_i.wake && sup_q == SUP_RUN) begin
         sup_q     <= SUP_CORE;
         sup_cnt_q <= 8'h00;
      end else if (slow_tick) begin
         case (sup_q)
            SUP_OFF: begin
               sup_q     <= SUP_REG; // RULE10
               sup_cnt_q <= 8'h00;
            end
            SUP_REG: begin
               if (sup_cnt_q == `SCR_REG_TICKS - 8'h01) begin
                  sup_q     <= SUP_CORE; // RULE10
                  sup_cnt_q <= 8'h00;
               end else begin
                  sup_cnt_q <= sup_cnt_q + 8'h01;
               end
            end
            SUP_CORE: begin
               if (sup_cnt_q == `SCR_CORE_TICKS - 8'h01) begin
                  sup_q     <= SUP_RUN;
                  sup_cnt_q <= 8'h00;
               end else begin
                  sup_cnt_q <= sup_cnt_q + 8'h01;
               end
            end
            SUP_RUN: sup_cnt_q <= 8'h00;
            default: sup_q     <= SUP_OFF;
         endcase
      end
   end

   // Brownout trip is blocked once software has disabled the detector
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         bod_trip_q <= 1'b0;
      end else begin
         bod_trip_q <= core_supply_low_i & ~cfg_q.bod_dis; // RULE2
      end
   end

   assign regulator_en_o = (sup_q != SUP_OFF); // RULE10
   assign core_reset_o   = (sup_q != SUP_RUN) | bod_trip_q; // RULE2

   ////////////////////////////////////////////////////////////////////////////
   // Reset controller

   // Pin input is ignored while we drive it, so our own pulse never retriggers
   assign user_low  = ~external_reset_pin_i & ~external_reset_pin_oe_o;
   assign rst_start = core_reset_o | req_i.sw | req_i.wdt | user_low;

   // Pulse stretched by a fixed count after the last cause goes away
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         erst_cnt_q <= `SCR_ERST_TICKS;
      end else if (rst_start) begin
         erst_cnt_q <= `SCR_ERST_TICKS; // RULE6
      end else if (slow_tick && erst_cnt_q != 8'h00) begin
         erst_cnt_q <= erst_cnt_q - 8'h01;
      end
   end

   assign sys_reset_o             = (erst_cnt_q != 8'h00); // RULE6
   assign external_reset_pin_o    = 1'b0; // Open drain: only pulls low
   assign external_reset_pin_oe_o = sys_reset_o; // RULE6

   // Most severe cause wins when several arrive together
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         cause_q <= scr_pkg::SCR_RC_GENERAL;
      end else if (backup_supply_low_i || bod_trip_q) begin
         cause_q <= scr_pkg::SCR_RC_GENERAL; // RULE5
      end else if (req_i.wdt) begin
         cause_q <= scr_pkg::SCR_RC_WATCHDOG; // RULE5
      end else if (req_i.sw) begin
         cause_q <= scr_pkg::SCR_RC_SOFTWARE; // RULE5
      end else if (user_low) begin
         cause_q <= scr_pkg::SCR_RC_USER; // RULE5
      end else if (req_i.wake && sup_q == SUP_RUN) begin
         cause_q <= scr_pkg::SCR_RC_WAKEUP; // RULE5
      end
   end

   assign reset_cause_o = cause_q;

   ////////////////////////////////////////////////////////////////////////////
   // Supply monitor

   // Sample counter powers the comparator one slow period in each window
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         smp_cnt_q <= 12'h000;
      end else if (!cfg_q.smon_en) begin
         smp_cnt_q <= 12'h000;
      end else if (slow_tick) begin
         if (smp_cnt_q >= smp_period(cfg_q.smon_smp) - 12'h001) begin
            smp_cnt_q <= 12'h000; // RULE4
         end else begin
            smp_cnt_q <= smp_cnt_q + 12'h001; // RULE4
         end
      end
   end

   assign smon_power_o = cfg_q.smon_en & (smp_cnt_q == 12'h000); // RULE3 RULE4
   assign smon_thr_o   = cfg_q.smon_thr; // RULE3

   // Sticky alarm; a new trip in the clearing cycle is kept
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         alarm_q <= 1'b0;
      end else if (smon_power_o && usb_phy_supply_low_i) begin
         alarm_q <= 1'b1; // RULE3
      end else if (smon_clr_i) begin
         alarm_q <= 1'b0;
      end
   end

   assign smon_alarm_o = alarm_q;

   ////////////////////////////////////////////////////////////////////////////
   // Slow clock source

   assign xtal_req = cfg_q.xtal32_en & cfg_q.xtal32_sel;

   // Switch once the crystal has had its start time; no way back but reset
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         slow_sel_q <= 1'b0; // RULE8
         xtal_cnt_q <= 8'h00;
      end else if (backup_supply_low_i) begin
         slow_sel_q <= 1'b0;
         xtal_cnt_q <= 8'h00;
      end else if (!slow_sel_q && !xtal_req) begin
         xtal_cnt_q <= 8'h00;
      end else if (!slow_sel_q && slow_tick) begin
         if (xtal_cnt_q == `SCR_XTAL_TICKS - 8'h01) begin
            slow_sel_q <= 1'b1; // RULE8
         end else begin
            xtal_cnt_q <= xtal_cnt_q + 8'h01;
         end
      end
   end

   assign slow_is_xtal_o = slow_sel_q;
   assign rc_slow_en_o   = ~slow_sel_q; // RULE9
   assign xtal32_en_o    = slow_sel_q | xtal_req; // RULE9
   assign xtal32_byp_o   = cfg_q.xtal32_byp; // RULE14
   assign main_byp_o     = cfg_q.main_byp; // RULE14
   // Amplifier stays off in bypass: the external clock drives the pin directly
   assign main_osc_en_o  = ~cfg_q.main_byp & // RULE14
                           (cfg_q.mck_src == scr_pkg::SCR_MCK_MAIN | usb_pll_req_i);
   assign frc_sel_o      = cfg_q.frc_sel; // RULE11
   assign mck_src_o      = cfg_q.mck_src; // RULE12

   ////////////////////////////////////////////////////////////////////////////
   // Clock enables

   // Registered limit keeps the divider compare off the config path
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         mck_lim_q <= 8'h00;
         usb_hs_pll_en_q <= 1'b0;
      end else begin
         mck_lim_q <= mck_lim(cfg_q.mck_src, cfg_q.frc_sel); // RULE12
         usb_hs_pll_en_q <= usb_pll_req_i & main_ref_12m_i; // RULE13
      end
   end

   scr_div #(
      .W (8)
   ) u_mck (
      .mclk_i (mclk_i),
      .rst_i  (rst_i),
      .en_i   (~sys_reset_o),
      .lim_i  (mck_lim_q),
      .tick_o (mck_tick)
   );

   // Programmable outputs divide the master clock by a power of two
   for (genvar i = 0; i < 3; i++) begin : g_pck
      scr_div #(
         .W (8)
      ) u_pck (
         .mclk_i (mclk_i),
         .rst_i  (rst_i),
         .en_i   (mck_tick & pck_on_i[i]),
         .lim_i  (8'((8'h01 << pck_pres_i[3*i +: 3]) - 8'h01)),
         .tick_o (pck_en_o[i]) // RULE15
      );
   end

   assign master_clock_en_o           = mck_tick; // RULE15
   assign free_running_cpu_clock_en_o = mck_tick;
   assign cpu_clk_en_o                = mck_tick & ~cpu_sleep_i; // RULE15
   assign periph_clk_en_o             = {NPER{mck_tick}} & periph_gate_i; // RULE15
   assign usb_hs_pll_en_o             = usb_hs_pll_en_q; // RULE13
   assign usb_hs_clock_en_o           = usb_hs_pll_en_q & usb_hs_pll_lock_i; // RULE13
   assign usb_hs_pll_mult_o           = `SCR_USB_HS_PLL_MULT; // RULE13
   assign systick_calib_o             = `SCR_SYSTICK_CAL; // RULE16

   ////////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);

   logic [15:0] gap_q;
   logic        seen_q;

   // Cycles since the last slow tick
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         gap_q  <= 16'h0000;
         seen_q <= 1'b0;
      end else if (slow_tick) begin
         gap_q  <= 16'h0000;
         seen_q <= 1'b1;
      end else begin
         gap_q  <= gap_q + 16'h0001;
      end
   end

   sequence sw_req_s;
      req_i.sw && !backup_supply_low_i;
   endsequence
   sequence pin_driven_s;
      external_reset_pin_oe_o && sys_reset_o && !external_reset_pin_o;
   endsequence

   por_restart_a: assert property (backup_supply_low_i |=> core_reset_o && !regulator_en_o) // RULE1
      else $error("backup POR did not restart the supply");
   bod_reset_a: assert property (core_supply_low_i && !cfg_q.bod_dis |=> core_reset_o) // RULE2
      else $error("brownout did not reset the core");
   smon_off_a: assert property (!cfg_q.smon_en |-> !smon_power_o) // RULE3
      else $error("supply monitor powered while disabled");
   smon_sample_a: assert property (cfg_q.smon_en && cfg_q.smon_smp == scr_pkg::SCR_SMP_2048 && // RULE4
      smon_power_o && slow_tick && !cfg_wr_i |=> !smon_power_o)
      else $error("sampled monitor stayed powered");
   cause_wdt_a: assert property (req_i.wdt && !backup_supply_low_i && !bod_trip_q // RULE5
      |=> reset_cause_o == scr_pkg::SCR_RC_WATCHDOG)
      else $error("watchdog cause not recorded");
   sw_pulse_a: assert property (sw_req_s |=> pin_driven_s [*2]) // RULE6
      else $error("software reset did not drive the pin");
   slow_gap_a: assert property (slow_tick && seen_q |-> gap_q == 16'(SLOW_DIV - 1)) // RULE7
      else $error("slow tick period wrong");
   xtal_switch_a: assert property ($rose(slow_sel_q) |-> $past(xtal_req)) // RULE8
      else $error("slow clock switched without software request");
   unused_off_a: assert property (slow_sel_q |-> !rc_slow_en_o && xtal32_en_o) // RULE9
      else $error("unused slow oscillator left on");
   reg_first_a: assert property ($fell(core_reset_o) |-> regulator_en_o && $past(regulator_en_o, 2)) // RULE10
      else $error("core reset released before regulator on");
   usb_ref_a: assert property (usb_hs_clock_en_o |-> $past(main_ref_12m_i && usb_pll_req_i)) // RULE13
      else $error("USB PLL ran without 12 MHz reference");

endmodule // scr_ctrl

// ===== scr_ctrl_tb_top.sv
// Self-checking testbench of the supply, reset and clock controller
`timescale 1ns/1ps
module scr_ctrl_tb_top;
   localparam int SDIV = 8; // Short slow tick keeps the run brief
   logic                mclk_i = 1'b0;
   logic                rst_i = 1'b1;
   logic                bk_low, cs_low, us_low, cfg_wr, smon_clr, button, pll_req, ref12;
   logic                lock, sleep, reg_en, core_rst, sys_rst, pin_o, pin_oe, smon_pwr;
   logic                alarm, rc_en, xt_en, xt_sel, xt_byp, mn_byp, pll_en, cpu_ce, mn_en;
   logic                mck_ce, usb_ce, fr_ce;
   wire logic           pin_i;
   scr_pkg::scr_cfg_t   cfg;
   scr_pkg::scr_req_t   req;
   scr_pkg::scr_cause_t cause;
   scr_pkg::scr_frc_t   frc;
   scr_pkg::scr_mck_t   master_clock;
   logic [7:0]          gate, pclk;
   logic [3:0]          thr;
   logic [5:0]          mult;
   logic [23:0]         cal;
   int                  fails = 0;
   int                  tests_run = 0;
   int                  cycles = 0;

   // Pin wire: the block pulls low while enabled, else the button sets it
   assign pin_i = pin_oe ? pin_o : button;

   always #2.5 mclk_i = ~mclk_i;

   scr_ctrl #(.SLOW_DIV(SDIV), .NPER(8)) scr_ctrl_inst (
      .mclk_i(mclk_i), .rst_i(rst_i), .backup_supply_low_i(bk_low),
      .core_supply_low_i(cs_low), .usb_phy_supply_low_i(us_low), .cfg_i(cfg),
      .cfg_wr_i(cfg_wr), .req_i(req), .smon_clr_i(smon_clr), .external_reset_pin_i(pin_i),
      .usb_pll_req_i(pll_req), .main_ref_12m_i(ref12), .usb_hs_pll_lock_i(lock),
      .cpu_sleep_i(sleep), .periph_gate_i(gate), .pck_on_i(3'h7), .pck_pres_i(9'h000),
      .regulator_en_o(reg_en), .core_reset_o(core_rst), .sys_reset_o(sys_rst),
      .external_reset_pin_o(pin_o), .external_reset_pin_oe_o(pin_oe),
      .reset_cause_o(cause), .smon_power_o(smon_pwr), .smon_thr_o(thr),
      .smon_alarm_o(alarm), .rc_slow_en_o(rc_en), .xtal32_en_o(xt_en),
      .slow_is_xtal_o(xt_sel), .xtal32_byp_o(xt_byp), .main_osc_en_o(mn_en),
      .main_byp_o(mn_byp), .frc_sel_o(frc), .mck_src_o(master_clock), .usb_hs_pll_en_o(pll_en),
      .usb_hs_pll_mult_o(mult), .cpu_clk_en_o(cpu_ce), .free_running_cpu_clock_en_o(fr_ce),
      .master_clock_en_o(mck_ce), .usb_hs_clock_en_o(usb_ce), .periph_clk_en_o(pclk),
      .pck_en_o(), .systick_calib_o(cal)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Compare and report
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Run ceiling; the whole sequence needs well under half of it
   always @(posedge mclk_i) begin
      cycles++;
      if (cycles == 60000) begin
         fails++;
         report_and_stop();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Waits for an output to reach a level; bounded so a stuck output cannot hang
   task automatic wait_for(input int sel, input logic lvl, output int n);
      logic v;
      n = 0;
      do begin
         @(posedge mclk_i);
         #1;
         n++;
         case (sel)
            0: v = reg_en;
            1: v = core_rst;
            2: v = sys_rst;
            3: v = xt_sel;
            default: v = mck_ce;
         endcase
      end while (v !== lvl && n < 2000);
      chk("wait bound", n < 2000, 1'b1);
   endtask

   // One-cycle configuration write, sampled once its edge has landed
   task automatic wr(input scr_pkg::scr_cfg_t c);
      @(posedge mclk_i);
      cfg <= c;
      cfg_wr <= 1'b1;
      @(posedge mclk_i);
      cfg_wr <= 1'b0;
      #1;
   endtask

   // Regulator first, core next, stretched system reset last
   task automatic power_up();
      int n;
      wait_for(0, 1'b1, n);
      chk("core held", core_rst, 1'b1);
      wait_for(1, 1'b0, n);
      chk("core delay", n, 7 * SDIV);
      chk("regulator on", reg_en, 1'b1);
      wait_for(2, 1'b0, n);
      chk("stretch", n, 8 * SDIV);
      chk("pin free", pin_oe, 1'b0);
      $display("test power_up done");
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      int n;
      scr_pkg::scr_cfg_t c;
      scr_pkg::scr_cause_t kind [3];
      logic [1:0] t_frc [5];
      logic [1:0] t_mck [5];
      int t_per [5];
      kind = '{scr_pkg::SCR_RC_SOFTWARE, scr_pkg::SCR_RC_WATCHDOG, scr_pkg::SCR_RC_USER};
      t_frc = '{2'h0, 2'h1, 2'h2, 2'h1, 2'h1};
      t_mck = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h2};
      t_per = '{50, 25, 16, 16, 2};
      {bk_low, cs_low, us_low, cfg_wr, smon_clr, pll_req, sleep} = '0;
      {button, ref12, lock} = 3'h7;
      gate = 8'h5a;
      cfg = '0;
      req = '0;
      c = '0;
      repeat (5) @(posedge mclk_i);
      #1;
      chk("regulator", reg_en, 1'b0);
      chk("pin drive", {pin_oe, pin_o}, 2'h2);
      chk("cause", cause, scr_pkg::SCR_RC_GENERAL);
      chk("fast rc", frc, scr_pkg::SCR_FRC_4M);
      chk("mck source", master_clock, scr_pkg::SCR_MCK_FRC);
      chk("slow osc", {rc_en, xt_en, xt_sel}, 3'h4);
      chk("monitor", smon_pwr, 1'b0);
      chk("calibration", cal, 24'h002904);
      chk("pll mult", mult, 6'h28);
      @(posedge mclk_i);
      rst_i <= 1'b0;
      power_up();
      // Software, watchdog and button resets; the pin pulse must not retrigger
      for (int k = 0; k < 3; k++) begin
         @(posedge mclk_i);
         if (k == 2) button <= 1'b0;
         else req <= (k == 0) ? 3'h4 : 3'h2;
         @(posedge mclk_i);
         button <= 1'b1;
         req <= '0;
         wait_for(2, 1'b1, n);
         chk("cause", cause, kind[k]);
         chk("pin driven", pin_oe, 1'b1);
         wait_for(2, 1'b0, n);
         chk("pulse length", n >= 7 * SDIV, 1'b1);
      end
      $display("test reset_sources done");
      // Wake-up re-resets the core; the regulator stays on
      @(posedge mclk_i);
      req <= 3'h1;
      @(posedge mclk_i);
      req <= '0;
      #1;
      chk("wake core", {core_rst, reg_en}, 2'h3);
      chk("wake cause", cause, scr_pkg::SCR_RC_WAKEUP);
      wait_for(1, 1'b0, n);
      // Brownout trips the core while enabled
      @(posedge mclk_i);
      cs_low <= 1'b1;
      @(posedge mclk_i);
      cs_low <= 1'b0;
      #1;
      chk("brownout", core_rst, 1'b1);
      @(posedge mclk_i);
      #1;
      chk("bo cause", cause, scr_pkg::SCR_RC_GENERAL);
      wait_for(1, 1'b0, n);
      wait_for(2, 1'b0, n);
      c.bod_dis = 1'b1;
      wr(c);
      cs_low <= 1'b1;
      repeat (20) @(posedge mclk_i);
      cs_low <= 1'b0;
      #1;
      chk("bod off", core_rst, 1'b0);
      $display("test brownout done");
      // Master clock rate for each source and fast RC setting
      for (int i = 0; i < 5; i++) begin
         c.frc_sel = scr_pkg::scr_frc_t'(t_frc[i]);
         c.mck_src = scr_pkg::scr_mck_t'(t_mck[i]);
         wr(c);
         chk("frc sel", frc, t_frc[i]);
         wait_for(4, 1'b1, n);
         chk("clock gates", {fr_ce, cpu_ce, pclk}, 10'h35a);
         wait_for(4, 1'b1, n);
         wait_for(4, 1'b1, n);
         chk("mck period", n, t_per[i]);
      end
      $display("test clocks done");
      // Supply monitor: continuous, alarm, clear, then sampled duty
      c.smon_en = 1'b1;
      c.smon_thr = 4'hc;
      wr(c);
      chk("threshold", thr, 4'hc);
      us_low <= 1'b1;
      repeat (2 * SDIV) @(posedge mclk_i);
      us_low <= 1'b0;
      #1;
      chk("alarm", {smon_pwr, alarm}, 2'h3);
      @(posedge mclk_i);
      smon_clr <= 1'b1;
      @(posedge mclk_i);
      smon_clr <= 1'b0;
      #1;
      chk("alarm clear", alarm, 1'b0);
      for (int m = 1; m < 3; m++) begin
         c.smon_smp = scr_pkg::scr_smp_t'(m);
         wr(c);
         repeat (4 * SDIV) @(posedge mclk_i);
         n = 0;
         repeat ((m == 1 ? 256 : 2048) * SDIV) begin
            @(posedge mclk_i);
            #1;
            n += int'(smon_pwr === 1'b1);
         end
         chk("sampled duty", n, SDIV);
      end
      $display("test monitor done");
      // Crystal selection, bypass, and the RC switched off
      {c.xtal32_en, c.xtal32_sel, c.xtal32_byp, c.main_byp} = 4'hf;
      wr(c);
      chk("xtal on", {xt_en, xt_byp, mn_byp, mn_en}, 4'he);
      wait_for(3, 1'b1, n);
      chk("xtal start", n <= 16 * SDIV + 1, 1'b1);
      chk("rc off", rc_en, 1'b0);
      // USB PLL with a 12 MHz reference; sw reset
      @(posedge mclk_i);
      {pll_req, req} <= 4'hc;
      @(posedge mclk_i);
      req <= '0;
      #1;
      chk("usb pll", {pll_en, usb_ce}, 2'h3);
      $display("test xtal_usb done");
      // Backup supply loss resets supply sequencing, slow clock, configuration and cause
      @(posedge mclk_i);
      bk_low <= 1'b1;
      @(posedge mclk_i);
      bk_low <= 1'b0;
      #1;
      chk("backup", {reg_en, core_rst, rc_en, xt_sel}, 4'h6);
      chk("backup cfg", {frc, master_clock}, 4'h0);
      chk("backup cause", cause, scr_pkg::SCR_RC_GENERAL);
      power_up();
      report_and_stop();
   end
endmodule // scr_ctrl_tb_top
